// ---- hdl/tsd_pkg.sv ----
`default_nettype none
package tsd_pkg;
  // widths
  localparam int DATA_W     = 32;
  localparam int SEL_W      = 8;
  localparam int OSC_CNT_W  = 16;
  localparam int NUM_OSC    = 4;
  localparam int CORE_W     = 8;
  localparam int REG_SEL_W  = 5;
  localparam int BP_W       = 2;
  localparam int CODE_W     = 3;
  localparam int MODE_W     = 8;

  // register numbers used as selector
  localparam logic [7:0] REG_BOOT_STATUS = 8'h03;
  localparam logic [7:0] REG_SECURITY    = 8'h05;
  localparam logic [7:0] REG_OSC_CTRL    = 8'h06;
  localparam logic [7:0] REG_OSC_CNT0    = 8'h07;
  localparam logic [7:0] REG_OSC_CNT1    = 8'h08;
  localparam logic [7:0] REG_OSC_CNT2    = 8'h09;
  localparam logic [7:0] REG_OSC_CNT3    = 8'h0A;
  localparam logic [7:0] REG_SAVED_SR    = 8'h10;
  localparam logic [7:0] REG_SAVED_PC    = 8'h11;
  localparam logic [7:0] REG_SAVED_SP    = 8'h12;
  localparam logic [7:0] REG_CORE_SEL    = 8'h13;
  localparam logic [7:0] REG_REG_SEL     = 8'h14;
  localparam logic [7:0] REG_CAUSE       = 8'h15;

  // field positions
  localparam int BOOT_TILE_LSB  = 16;
  localparam int BOOT_OTP_BIT   = 8;
  localparam int OSC_TILE_BIT   = 1;
  localparam int OSC_PERIPH_BIT = 0;
  localparam int CAUSE_BP_LSB   = 16;
  localparam int CAUSE_CORE_LSB = 8;

  // reset values
  localparam logic [1:0]        OSC_CTRL_RST = 2'h0;
  localparam logic [DATA_W-1:0] SAVED_RST    = 32'h0000_0000;
  localparam logic [CORE_W-1:0] CORE_RST     = 8'h00;
  localparam logic [BP_W-1:0]   BP_RST       = 2'h0;
  localparam logic [MODE_W-1:0] MODE_RST     = 8'h00;

  // debug interrupt cause codes
  typedef enum logic [CODE_W-1:0] {
    CAUSE_NONE       = 3'h0,
    CAUSE_HOST       = 3'h1,
    CAUSE_DEBUG_CALL = 3'h2,
    CAUSE_IBRK       = 3'h3,
    CAUSE_DWATCH     = 3'h4,
    CAUSE_RWATCH     = 3'h5
  } tsd_cause_t;
endpackage : tsd_pkg
`default_nettype wire

// ---- hdl/tsd_cause_if.sv ----
`default_nettype none
interface tsd_cause_if;
  import tsd_pkg::*;
  tsd_cause_t             code;
  logic [BP_W-1:0]        bp_num;
  logic [CORE_W-1:0]      core_num;
  modport enc (output code, output bp_num, output core_num);
  modport top (input code, input bp_num, input core_num);
endinterface : tsd_cause_if
`default_nettype wire

// ---- hdl/tsd_ring_counter.sv ----
`default_nettype none
module tsd_ring_counter
  import tsd_pkg::*;
(
  input  wire logic                 sys_clk,
  input  wire logic                 rstn,
  input  wire logic                 osc_level,
  input  wire logic                 run,
  output logic [OSC_CNT_W-1:0]      count
);
  typedef struct packed {
    logic                 sync1;
    logic                 sync2;
    logic                 prev;
    logic [OSC_CNT_W-1:0] cnt;
  } tsd_cnt_state_t;

  // defined start so the count is never unknown; reset leaves it alone
  tsd_cnt_state_t s_reg = '0;
  tsd_cnt_state_t s_next;

  // edges are seen only up to half the tile clock rate
  always_comb
  begin
    s_next       = s_reg;
    s_next.sync1 = osc_level;
    s_next.sync2 = s_reg.sync1;
    s_next.prev  = s_reg.sync2;
    if (run && s_reg.sync2 && !s_reg.prev)
    begin
      s_next.cnt = s_reg.cnt + 16'h0001;
    end
    // count survives reset so the bits keep their entropy
    if (!rstn)
    begin
      s_next.sync1 = 1'b0;
      s_next.sync2 = 1'b0;
      s_next.prev  = 1'b0;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    s_reg <= s_next;
  end

  assign count = s_reg.cnt;

  AST_CNT_KEEP: assert property (@(posedge sys_clk)
    !rstn ##1 !rstn |-> $stable(count))
    else $error("counter changed during reset");
  AST_CNT_STEP: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    (run && s_reg.sync2 && !s_reg.prev) |=>
    count == $past(count) + 16'h0001)
    else $error("counter missed an oscillator edge");
endmodule : tsd_ring_counter
`default_nettype wire

// ---- hdl/tsd_cause_enc.sv ----
`default_nettype none
module tsd_cause_enc
  import tsd_pkg::*;
(
  input  wire logic              host_jtag_req,
  input  wire logic              debug_call_hit,
  input  wire logic [CORE_W-1:0] debug_call_core,
  input  wire logic [3:0]        ibrk_hit,
  input  wire logic [3:0]        dwatch_hit,
  input  wire logic [3:0]        rwatch_hit,
  input  wire logic [CORE_W-1:0] hit_core,
  tsd_cause_if.enc               cause
);
  // lowest set index among four hit lines
  function automatic logic [BP_W-1:0] lowest(input logic [3:0] v);
    logic [BP_W-1:0] n;
    n = 2'h0;
    for (int i = 3; i >= 0; i--)
    begin
      if (v[i])
      begin
        n = i[BP_W-1:0];
      end
    end
    return n;
  endfunction : lowest

  // cause priority follows the numeric order of the codes
  always_comb
  begin
    cause.code     = CAUSE_NONE;
    cause.bp_num   = BP_RST;
    cause.core_num = CORE_RST;
    if (host_jtag_req)
    begin
      cause.code = CAUSE_HOST;
    end
    else if (debug_call_hit)
    begin
      cause.code     = CAUSE_DEBUG_CALL;
      cause.core_num = debug_call_core;
    end
    else if (|ibrk_hit)
    begin
      cause.code     = CAUSE_IBRK;
      cause.bp_num   = lowest(ibrk_hit);
      cause.core_num = hit_core;
    end
    else if (|dwatch_hit)
    begin
      cause.code     = CAUSE_DWATCH;
      cause.bp_num   = lowest(dwatch_hit);
      cause.core_num = hit_core;
    end
    else if (|rwatch_hit)
    begin
      cause.code     = CAUSE_RWATCH;
      cause.bp_num   = lowest(rwatch_hit);
      cause.core_num = hit_core;
    end
  end
endmodule : tsd_cause_enc
`default_nettype wire

// ---- hdl/tsd_status_regs.sv ----
`default_nettype none
module tsd_status_regs
  import tsd_pkg::*;
(
  input  wire logic              sys_clk,
  input  wire logic              rstn,
  input  wire logic              ps_rd_en,
  input  wire logic              ps_wr_en,
  input  wire logic [SEL_W-1:0]  ps_sel,
  input  wire logic [DATA_W-1:0] ps_wdata,
  output logic [DATA_W-1:0]      ps_rdata,
  output logic                   ps_rvalid,
  output logic                   ps_err,
  input  wire logic              debug_mode,
  input  wire logic [CORE_W-1:0] tile_number,
  input  wire logic              otp_boot_en,
  input  wire logic [MODE_W-1:0] boot_mode_pins,
  input  wire logic [DATA_W-1:0] security_word,
  input  wire logic [3:0]        osc_level,
  output logic [3:0]             osc_run,
  input  wire logic              dbg_enter,
  input  wire logic [DATA_W-1:0] saved_status_in,
  input  wire logic [DATA_W-1:0] saved_program_counter_in,
  input  wire logic [DATA_W-1:0] saved_stack_pointer_in,
  input  wire logic              host_jtag_req,
  input  wire logic              debug_call_hit,
  input  wire logic [CORE_W-1:0] debug_call_core,
  input  wire logic [3:0]        ibrk_hit,
  input  wire logic [3:0]        dwatch_hit,
  input  wire logic [3:0]        rwatch_hit,
  input  wire logic [CORE_W-1:0] hit_core
);
  ////////////////////////////////////////////////////////////////////////////
  // state
  typedef struct packed {
    logic [MODE_W-1:0]    mode_s1;
    logic [MODE_W-1:0]    mode_s2;
    logic [1:0]           osc_ctrl;
    logic [DATA_W-1:0]    saved_sr;
    logic [DATA_W-1:0]    saved_pc;
    logic [DATA_W-1:0]    saved_sp;
    logic [CORE_W-1:0]    core_sel;
    logic [REG_SEL_W-1:0] reg_sel;
    logic [BP_W-1:0]      bp_num;
    logic [CORE_W-1:0]    cause_core;
    logic [CODE_W-1:0]    cause_code;
    logic [DATA_W-1:0]    rdata;
    logic                 rvalid;
    logic                 err;
  } tsd_regs_state_t;

  localparam tsd_regs_state_t STATE_RST = '{
    mode_s1:    MODE_RST,
    mode_s2:    MODE_RST,
    osc_ctrl:   OSC_CTRL_RST,
    saved_sr:   SAVED_RST,
    saved_pc:   SAVED_RST,
    saved_sp:   SAVED_RST,
    core_sel:   CORE_RST,
    reg_sel:    5'h00,
    bp_num:     BP_RST,
    cause_core: CORE_RST,
    cause_code: CAUSE_NONE,
    rdata:      SAVED_RST,
    rvalid:     1'b0,
    err:        1'b0
  };

  tsd_regs_state_t s_reg;
  tsd_regs_state_t s_next;

  logic [OSC_CNT_W-1:0] osc_count [NUM_OSC];
  logic [DATA_W-1:0]    rd_word;

  tsd_cause_if cause_bus ();

  ////////////////////////////////////////////////////////////////////////////
  // decode helpers
  function automatic logic is_debug_reg(input logic [SEL_W-1:0] sel);
    return (sel >= REG_SAVED_SR) && (sel <= REG_CAUSE);
  endfunction : is_debug_reg

  function automatic logic is_mapped(input logic [SEL_W-1:0] sel);
    return (sel == REG_BOOT_STATUS) || (sel == REG_SECURITY) ||
           ((sel >= REG_OSC_CTRL) && (sel <= REG_OSC_CNT3)) ||
           is_debug_reg(sel);
  endfunction : is_mapped

  // registers that accept a write at all
  function automatic logic is_writable(input logic [SEL_W-1:0] sel);
    return (sel == REG_OSC_CTRL) ||
           ((sel >= REG_SAVED_PC) && (sel <= REG_CAUSE));
  endfunction : is_writable

  ////////////////////////////////////////////////////////////////////////////
  // oscillators: tile pair 0,1 and peripheral pair 2,3
  genvar gi;
  generate
    for (gi = 0; gi < NUM_OSC; gi++)
    begin : g_osc
      // oscillator runs off-clock; its level is synchronised here and its
      // edges counted on the tile clock
      tsd_ring_counter u_cnt (
        .sys_clk   (sys_clk),
        .rstn      (rstn),
        .osc_level (osc_level[gi]),
        .run       (osc_run[gi]),
        .count     (osc_count[gi])
      );
    end
  endgenerate

  // pair enables straight from the control bits
  assign osc_run = {{2{s_reg.osc_ctrl[OSC_PERIPH_BIT]}},
                    {2{s_reg.osc_ctrl[OSC_TILE_BIT]}}};

  ////////////////////////////////////////////////////////////////////////////
  // debug cause encoder
  tsd_cause_enc u_enc (
    .host_jtag_req   (host_jtag_req),
    .debug_call_hit  (debug_call_hit),
    .debug_call_core (debug_call_core),
    .ibrk_hit        (ibrk_hit),
    .dwatch_hit      (dwatch_hit),
    .rwatch_hit      (rwatch_hit),
    .hit_core        (hit_core),
    .cause           (cause_bus.enc)
  );

  ////////////////////////////////////////////////////////////////////////////
  // read mux; reserved positions are zero-filled
  always_comb
  begin
    rd_word = 32'h0000_0000;
    case (ps_sel)
      REG_BOOT_STATUS:
      begin
        rd_word[BOOT_TILE_LSB +: CORE_W] = tile_number;
        rd_word[BOOT_OTP_BIT]            = otp_boot_en;
        rd_word[MODE_W-1:0]              = s_reg.mode_s2;
      end
      REG_SECURITY:
        rd_word = security_word;
      REG_OSC_CTRL:
        rd_word[1:0] = s_reg.osc_ctrl;
      // counter reads are only stable while stopped
      REG_OSC_CNT0:
        rd_word[OSC_CNT_W-1:0] = osc_count[0];
      REG_OSC_CNT1:
        rd_word[OSC_CNT_W-1:0] = osc_count[1];
      REG_OSC_CNT2:
        rd_word[OSC_CNT_W-1:0] = osc_count[2];
      REG_OSC_CNT3:
        rd_word[OSC_CNT_W-1:0] = osc_count[3];
      REG_SAVED_SR:
        rd_word = s_reg.saved_sr;
      REG_SAVED_PC:
        rd_word = s_reg.saved_pc;
      REG_SAVED_SP:
        rd_word = s_reg.saved_sp;
      REG_CORE_SEL:
        rd_word[CORE_W-1:0] = s_reg.core_sel;
      REG_REG_SEL:
        rd_word[REG_SEL_W-1:0] = s_reg.reg_sel;
      REG_CAUSE:
      begin
        rd_word[CAUSE_BP_LSB +: BP_W]     = s_reg.bp_num;
        rd_word[CAUSE_CORE_LSB +: CORE_W] = s_reg.cause_core;
        rd_word[CODE_W-1:0]               = s_reg.cause_code;
      end
      default:
        rd_word = 32'h0000_0000;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // next state: access port, debug capture, pin sync
  always_comb
  begin
    s_next         = s_reg;
    s_next.mode_s1 = boot_mode_pins;
    s_next.mode_s2 = s_reg.mode_s1;
    s_next.rvalid  = ps_rd_en;
    s_next.err     = 1'b0;
    // debug registers need debug mode for both directions
    if (ps_rd_en)
    begin
      if (is_mapped(ps_sel) && (debug_mode || !is_debug_reg(ps_sel)))
      begin
        s_next.rdata = rd_word;
      end
      else
      begin
        s_next.rdata = 32'h0000_0000;
        s_next.err   = 1'b1;
      end
    end
    if (ps_wr_en)
    begin
      if (!is_writable(ps_sel) ||
          (is_debug_reg(ps_sel) && !debug_mode))
      begin
        s_next.err = 1'b1;
      end
      else
      begin
        case (ps_sel)
          REG_OSC_CTRL:
            s_next.osc_ctrl = ps_wdata[1:0];
          REG_SAVED_PC:
            s_next.saved_pc = ps_wdata;
          REG_SAVED_SP:
            s_next.saved_sp = ps_wdata;
          REG_CORE_SEL:
            s_next.core_sel = ps_wdata[CORE_W-1:0];
          REG_REG_SEL:
            s_next.reg_sel = ps_wdata[REG_SEL_W-1:0];
          REG_CAUSE:
          begin
            s_next.bp_num     = ps_wdata[CAUSE_BP_LSB +: BP_W];
            s_next.cause_core = ps_wdata[CAUSE_CORE_LSB +: CORE_W];
            s_next.cause_code = ps_wdata[CODE_W-1:0];
          end
          default:
            s_next.err = 1'b1;
        endcase
      end
    end
    // hardware entry wins over a write in the same cycle
    if (dbg_enter)
    begin
      s_next.saved_sr   = saved_status_in;
      s_next.saved_pc   = saved_program_counter_in;
      s_next.saved_sp   = saved_stack_pointer_in;
      s_next.bp_num     = cause_bus.bp_num;
      s_next.cause_core = cause_bus.core_num;
      s_next.cause_code = cause_bus.code;
    end
    if (!rstn)
    begin
      s_next = STATE_RST;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    s_reg <= s_next;
  end

  // registered answer, one cycle after the request
  assign ps_rdata  = s_reg.rdata;
  assign ps_rvalid = s_reg.rvalid;
  assign ps_err    = s_reg.err;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  AST_BOOT_TILE: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    (ps_rd_en && ps_sel == REG_BOOT_STATUS) |=>
    ps_rvalid && ps_rdata[23:16] == $past(tile_number))
    else $error("tile number wrong in boot status");

  AST_BOOT_OTP: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    (ps_rd_en && ps_sel == REG_BOOT_STATUS) |=>
    ps_rdata[8] == $past(otp_boot_en) && ps_rdata[15:9] == 7'h00)
    else $error("otp boot bit wrong");

  // the pin synchroniser holds zero until two edges after reset
  AST_BOOT_PINS: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    (ps_rd_en && ps_sel == REG_BOOT_STATUS && $stable(boot_mode_pins)
     && $past(boot_mode_pins) == $past(boot_mode_pins, 2)
     && $past(rstn) && $past(rstn, 2)) |=>
    ps_rdata[7:0] == $past(boot_mode_pins, 2))
    else $error("boot mode pins not reflected");

  AST_SECURITY: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    (ps_rd_en && ps_sel == REG_SECURITY) |=>
    ps_rdata == $past(security_word) && !ps_err)
    else $error("security copy wrong");

  AST_OSC_RESET: assert property (@(posedge sys_clk)
    !rstn |=> osc_run == 4'h0)
    else $error("oscillators running after reset");

  AST_OSC_WRITE: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    (ps_wr_en && ps_sel == REG_OSC_CTRL) |=>
    osc_run == {{2{$past(ps_wdata[0])}}, {2{$past(ps_wdata[1])}}})
    else $error("oscillator pair enable wrong");

  AST_CNT_READ: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    (ps_rd_en && ps_sel == REG_OSC_CNT3) |=>
    ps_rdata[31:16] == 16'h0000 &&
    ps_rdata[15:0] == $past(osc_count[3]))
    else $error("counter read wrong");

  AST_SAVE: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    dbg_enter |=> s_reg.saved_sr == $past(saved_status_in) &&
    s_reg.saved_pc == $past(saved_program_counter_in) &&
    s_reg.saved_sp == $past(saved_stack_pointer_in))
    else $error("debug entry did not save state");

  // a write, an edge with no write to it, then a readback
  AST_SEL_WRITE: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    (ps_wr_en && debug_mode && ps_sel == REG_CORE_SEL)
    ##1 !(ps_wr_en && ps_sel == REG_CORE_SEL)
    ##1 (ps_rd_en && debug_mode && ps_sel == REG_CORE_SEL) |=>
    ps_rdata == {24'h000000, $past(ps_wdata[7:0], 3)})
    else $error("core select readback wrong");

  AST_REG_SEL: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    (ps_wr_en && debug_mode && ps_sel == REG_REG_SEL) |=>
    s_reg.reg_sel == $past(ps_wdata[4:0]))
    else $error("register select not stored");

  AST_BP_LOW: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    (dbg_enter && !host_jtag_req && !debug_call_hit &&
     ibrk_hit == 4'hA) |=>
    s_reg.bp_num == 2'h1 && s_reg.cause_code == 3'h3)
    else $error("lowest breakpoint not taken");

  AST_HOST_CAUSE: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    (dbg_enter && host_jtag_req) |=>
    s_reg.cause_code == 3'h1 && s_reg.cause_core == 8'h00)
    else $error("host cause wrong");

  AST_RESERVED: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    (ps_rd_en && ps_sel == REG_OSC_CTRL) |=>
    ps_rdata[31:2] == 30'h0)
    else $error("reserved bits not zero");
endmodule : tsd_status_regs
`default_nettype wire

// ---- dv/tsd_core_model.sv ----
`default_nettype none
module tsd_core_model
  import tsd_pkg::*;
(
  input  wire logic              sys_clk,
  output logic                   ps_rd_en,
  output logic                   ps_wr_en,
  output logic [SEL_W-1:0]       ps_sel,
  output logic [DATA_W-1:0]      ps_wdata,
  input  wire logic [DATA_W-1:0] ps_rdata,
  input  wire logic              ps_rvalid,
  input  wire logic              ps_err
);
  timeunit 1ns;
  timeprecision 1ps;

  // idle bus at time zero
  initial
  begin
    ps_rd_en = 1'b0;
    ps_wr_en = 1'b0;
    ps_sel   = 8'hFF;
    ps_wdata = 32'h0000_0000;
  end

  //////////////////////////////////////////////////////////////////////
  // one status access: request stands for one edge, answer taken at
  // the next edge, then released to an inverted pattern so a stale
  // value is never mistaken for a live one
  task automatic access(
    input  logic              rd,
    input  logic [SEL_W-1:0]  sel,
    input  logic [DATA_W-1:0] wd,
    output logic [DATA_W-1:0] rdat,
    output logic              err,
    output logic              vld
  );
    @(posedge sys_clk);
    #1;
    ps_rd_en = rd;
    ps_wr_en = ~rd;
    ps_sel   = sel;
    ps_wdata = wd;
    @(posedge sys_clk);
    #1;
    rdat     = ps_rdata;
    err      = ps_err;
    vld      = ps_rvalid;
    ps_rd_en = 1'b0;
    ps_wr_en = 1'b0;
    ps_sel   = ~sel;
    ps_wdata = ~wd;
  endtask : access
endmodule : tsd_core_model
`default_nettype wire

// ---- dv/tile_status_debug_regs_tb_top.sv ----
`default_nettype none
module tile_status_debug_regs_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import tsd_pkg::*;

  logic              sys_clk = 1'b0;
  logic              rstn    = 1'b0;
  logic              ps_rd_en, ps_wr_en, ps_rvalid, ps_err;
  logic [SEL_W-1:0]  ps_sel;
  logic [DATA_W-1:0] ps_wdata, ps_rdata, security_word;
  logic              debug_mode, otp_boot_en, dbg_enter;
  logic              host_jtag_req, debug_call_hit;
  logic [CORE_W-1:0] tile_number, debug_call_core, hit_core;
  logic [MODE_W-1:0] boot_mode_pins;
  logic [DATA_W-1:0] saved_status_in, saved_program_counter_in;
  logic [DATA_W-1:0] saved_stack_pointer_in;
  logic [3:0]        osc_level, osc_run, ibrk_hit, dwatch_hit, rwatch_hit;
  int                n_mismatch   = 0;
  int                total_checks = 0;

  // 25 MHz system clock
  always #20 sys_clk = ~sys_clk;

  // rings stand still when off; half periods unrelated to sys_clk
  always #83 if (osc_run[0] === 1'b1) osc_level[0] = ~osc_level[0];
  always #97 if (osc_run[1] === 1'b1) osc_level[1] = ~osc_level[1];
  always #111 if (osc_run[2] === 1'b1) osc_level[2] = ~osc_level[2];
  always #131 if (osc_run[3] === 1'b1) osc_level[3] = ~osc_level[3];

  tsd_status_regs i_dut (
    .sys_clk, .rstn, .ps_rd_en, .ps_wr_en, .ps_sel, .ps_wdata,
    .ps_rdata, .ps_rvalid, .ps_err, .debug_mode, .tile_number,
    .otp_boot_en, .boot_mode_pins, .security_word, .osc_level,
    .osc_run, .dbg_enter, .saved_status_in, .saved_program_counter_in,
    .saved_stack_pointer_in, .host_jtag_req, .debug_call_hit,
    .debug_call_core, .ibrk_hit, .dwatch_hit, .rwatch_hit, .hit_core
  );

  tsd_core_model i_core (
    .sys_clk, .ps_rd_en, .ps_wr_en, .ps_sel, .ps_wdata, .ps_rdata,
    .ps_rvalid, .ps_err
  );

  //////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [DATA_W-1:0] exp,
                     input logic [DATA_W-1:0] got);
    total_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : cyc

  // valid is only judged on accepted reads
  task automatic rd_chk(input logic [SEL_W-1:0] sel,
                        input logic [DATA_W-1:0] exp, input logic xerr);
    logic [DATA_W-1:0] d;
    logic              e;
    logic              v;
    i_core.access(1'b1, sel, 32'h0, d, e, v);
    chk($sformatf("reg %h data", sel), exp, d);
    chk($sformatf("reg %h err", sel), {31'h0, xerr}, {31'h0, e});
    if (!xerr)
      chk($sformatf("reg %h valid", sel), 32'h1, {31'h0, v});
  endtask : rd_chk

  task automatic wr_chk(input logic [SEL_W-1:0] sel,
                        input logic [DATA_W-1:0] wd, input logic xerr);
    logic [DATA_W-1:0] d;
    logic              e;
    logic              v;
    i_core.access(1'b0, sel, wd, d, e, v);
    chk($sformatf("wr %h err", sel), {31'h0, xerr}, {31'h0, e});
  endtask : wr_chk

  //////////////////////////////////////////////////////////////////////
  // mode pins pass a synchroniser, so allow it to settle
  task automatic t_boot();
    cyc(2);
    rd_chk(REG_BOOT_STATUS, 32'h003C_01A6, 1'b0);
    tile_number    = 8'hC3;
    otp_boot_en    = 1'b0;
    boot_mode_pins = 8'h59;
    cyc(4);
    rd_chk(REG_BOOT_STATUS, 32'h00C3_0059, 1'b0);
    wr_chk(REG_BOOT_STATUS, 32'hFFFF_FFFF, 1'b1);
    wr_chk(REG_SECURITY, 32'h0, 1'b1);
    rd_chk(REG_SECURITY, 32'h5EC0_93D1, 1'b0);
    rd_chk(8'h04, 32'h0, 1'b1);
    rd_chk(8'h0B, 32'h0, 1'b1);
    rd_chk(8'h16, 32'h0, 1'b1);
  endtask : t_boot

  task automatic t_osc();
    logic [DATA_W-1:0] c [NUM_OSC];
    logic [DATA_W-1:0] p [NUM_OSC];
    logic              e;
    logic              v;
    rd_chk(REG_OSC_CTRL, 32'h0, 1'b0);
    // counts while every ring is stopped, to see them move later
    for (int i = 0; i < NUM_OSC; i++)
    begin
      i_core.access(1'b1, REG_OSC_CNT0 + SEL_W'(i), 32'h0, p[i], e, v);
    end
    wr_chk(REG_OSC_CTRL, 32'hFFFF_FFFE, 1'b0);
    chk("osc run", 32'h3, {28'h0, osc_run});
    rd_chk(REG_OSC_CTRL, 32'h2, 1'b0);
    wr_chk(REG_OSC_CTRL, 32'h1, 1'b0);
    chk("osc run", 32'hC, {28'h0, osc_run});
    wr_chk(REG_OSC_CTRL, 32'h3, 1'b0);
    cyc(200);
    wr_chk(REG_OSC_CTRL, 32'h0, 1'b0);
    cyc(6);
    for (int i = 0; i < NUM_OSC; i++)
    begin
      i_core.access(1'b1, REG_OSC_CNT0 + SEL_W'(i), 32'h0, c[i], e, v);
      chk("count upper", 32'h0, c[i] & 32'hFFFF_0000);
      chk("count moved", 32'h1, {31'h0, c[i] != p[i]});
      wr_chk(REG_OSC_CNT0 + SEL_W'(i), 32'h0, 1'b1);
    end
    // a mid-run reset must leave the stopped counts untouched
    rstn = 1'b0;
    cyc(4);
    rstn = 1'b1;
    rd_chk(REG_OSC_CTRL, 32'h0, 1'b0);
    for (int i = 0; i < NUM_OSC; i++)
    begin
      rd_chk(REG_OSC_CNT0 + SEL_W'(i), c[i], 1'b0);
    end
  endtask : t_osc

  // one debugger entry, then read back cause and saved state
  task automatic hit(input logic hj, input logic dc, input logic [3:0] ib,
                     input logic [3:0] dw, input logic [3:0] rw,
                     input logic [DATA_W-1:0] exp);
    @(posedge sys_clk);
    #1;
    host_jtag_req            = hj;
    debug_call_hit           = dc;
    ibrk_hit                 = ib;
    dwatch_hit               = dw;
    rwatch_hit               = rw;
    saved_status_in          = exp ^ 32'hA5A5_0001;
    saved_program_counter_in = ~exp;
    saved_stack_pointer_in   = exp + 32'h40;
    dbg_enter                = 1'b1;
    @(posedge sys_clk);
    #1;
    dbg_enter = 1'b0;
    {host_jtag_req, debug_call_hit, ibrk_hit, dwatch_hit, rwatch_hit} = '0;
    rd_chk(REG_CAUSE, exp, 1'b0);
    rd_chk(REG_SAVED_SR, exp ^ 32'hA5A5_0001, 1'b0);
    rd_chk(REG_SAVED_PC, ~exp, 1'b0);
    rd_chk(REG_SAVED_SP, exp + 32'h40, 1'b0);
  endtask : hit

  task automatic t_dbg();
    debug_mode = 1'b0;
    rd_chk(REG_SAVED_PC, 32'h0, 1'b1);
    wr_chk(REG_CORE_SEL, 32'h7, 1'b1);
    debug_mode = 1'b1;
    rd_chk(REG_CAUSE, 32'h0, 1'b0);
    rd_chk(REG_CORE_SEL, 32'h0, 1'b0);
    wr_chk(REG_CORE_SEL, 32'hFFFF_FFFF, 1'b0);
    rd_chk(REG_CORE_SEL, 32'h0000_00FF, 1'b0);
    wr_chk(REG_REG_SEL, 32'hFFFF_FFFF, 1'b0);
    rd_chk(REG_REG_SEL, 32'h0000_001F, 1'b0);
    wr_chk(REG_SAVED_SR, 32'h1, 1'b1);
    wr_chk(REG_CAUSE, 32'hFFFF_FFFF, 1'b0);
    rd_chk(REG_CAUSE, 32'h0003_FF07, 1'b0);
    hit(1'b1, 1'b1, 4'hF, 4'h0, 4'h0, 32'h0000_0001);
    hit(1'b0, 1'b1, 4'h1, 4'h0, 4'h0, 32'h0000_5A02);
    hit(1'b0, 1'b0, 4'hA, 4'hF, 4'h0, 32'h0001_3C03);
    hit(1'b0, 1'b0, 4'h0, 4'hA, 4'h1, 32'h0001_3C04);
    hit(1'b0, 1'b0, 4'h0, 4'h0, 4'h8, 32'h0003_3C05);
  endtask : t_dbg

  //////////////////////////////////////////////////////////////////////
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : end_of_test

  // cut a hang short
  initial
  begin
    #2_000_000;
    n_mismatch++;
    $display("CHECK FAILED run length expected end seen timeout");
    end_of_test();
  end

  // main sequence
  initial
  begin
    debug_mode      = 1'b0;
    tile_number     = 8'h3C;
    otp_boot_en     = 1'b1;
    boot_mode_pins  = 8'hA6;
    security_word   = 32'h5EC0_93D1;
    osc_level       = 4'h0;
    dbg_enter       = 1'b0;
    host_jtag_req   = 1'b0;
    debug_call_hit  = 1'b0;
    debug_call_core = 8'h5A;
    hit_core        = 8'h3C;
    {ibrk_hit, dwatch_hit, rwatch_hit} = '0;
    saved_status_in          = 32'h0;
    saved_program_counter_in = 32'h0;
    saved_stack_pointer_in   = 32'h0;
    cyc(4);
    rstn = 1'b1;
    t_boot();
    t_osc();
    t_dbg();
    end_of_test();
  end
endmodule : tile_status_debug_regs_tb_top
`default_nettype wire
